/* src/lstat_pkg.sv */
package lstat_pkg;

   // ==========================================================
   // timing
   localparam int unsigned CLK_MHZ        = 50;
   localparam int unsigned FRAME_LOST_US  = 3000;
   localparam int unsigned FRAME_LOST_CYC = FRAME_LOST_US * CLK_MHZ;

   // ==========================================================
   // widths
   localparam int unsigned ADDR_W  = 12;
   localparam int unsigned CNT_W   = 32;
   localparam int unsigned NUM_CNT = 7;
   localparam int unsigned NUM_FLG = 11;

   // ==========================================================
   // register byte offsets
   localparam logic [11:0] REG_CTRL       = 12'h000;
   localparam logic [11:0] REG_SNAP       = 12'h004;
   localparam logic [11:0] REG_FLAGS      = 12'h008;
   localparam logic [11:0] REG_LABEL      = 12'h00c;
   localparam logic [11:0] REG_CNT_BASE   = 12'h010;
   localparam logic [11:0] REG_LIVE_FLAGS = 12'h02c;

   // ==========================================================
   // field positions and reset values
   localparam int unsigned CTRL_WAN_BIT  = 0;
   localparam int unsigned SNAP_TAKE_BIT = 0;
   localparam logic        CTRL_WAN_RST  = 1'b0;

   // flag bit positions
   localparam int unsigned FLG_RX_ALARM_IND   = 0;
   localparam int unsigned FLG_RX_LOCK_ERR    = 1;
   localparam int unsigned FLG_RX_POWER_ALARM = 2;
   localparam int unsigned FLG_SIGNAL_LOST    = 3;
   localparam int unsigned FLG_CLOCK_LOST     = 4;
   localparam int unsigned FLG_FRAME_UNLOCKED = 5;
   localparam int unsigned FLG_FRAME_LOST     = 6;
   localparam int unsigned FLG_POINTER_LOST   = 7;
   localparam int unsigned FLG_HIGH_ERR_RATE  = 8;
   localparam int unsigned FLG_LOCAL_FAULT    = 9;
   localparam int unsigned FLG_REMOTE_FAULT   = 10;

   // counter indices, register at REG_CNT_BASE + 4*index
   localparam int unsigned CNT_FRAME_CHECK   = 0;
   localparam int unsigned CNT_BAD_PACKET    = 1;
   localparam int unsigned CNT_GOOD_PACKET   = 2;
   localparam int unsigned CNT_RX_FIFO       = 3;
   localparam int unsigned CNT_SECTION_PAR   = 4;
   localparam int unsigned CNT_LINE_PAR      = 5;
   localparam int unsigned CNT_PATH_PAR      = 6;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic rx_err;
      logic rx_lock_err;
      logic rx_power_alarm;
   } lstat_optics_t;

   typedef struct packed {
      logic signal_lost;
      logic clock_lost;
      logic frame_unlocked;
      logic pointer_lost;
      logic high_error_rate;
      logic local_fault;
      logic remote_fault;
   } lstat_framer_t;

   typedef struct packed {
      logic frame_check_err;
      logic bad_packet;
      logic good_packet;
      logic rx_fifo_err;
      logic section_parity_err;
      logic line_parity_err;
      logic path_parity_err;
   } lstat_event_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_ACK  = 2'b10
   } lstat_bus_st_t;

   typedef struct packed {
      lstat_bus_st_t                   st;
      logic                            pready;
      logic                            pslverr;
      logic [31:0]                     prdata;
      logic                            wan_mode;
      logic [NUM_FLG-1:0]              flags;
      logic [NUM_FLG-1:0]              snap_flags;
      logic [31:0]                     unlock_cnt;
      logic [NUM_CNT-1:0][CNT_W-1:0]   cnt;
      logic [NUM_CNT-1:0][CNT_W-1:0]   snap_cnt;
      logic [7:0]                      label;
      logic [7:0]                      snap_label;
   } lstat_state_t;

endpackage

/* src/lstat_top.sv */
`timescale 1ns/10ps
module lstat_top #(
   parameter int unsigned FRAME_LOST_CYC = lstat_pkg::FRAME_LOST_CYC
) (
   input  wire logic                         clk_i,
   input  wire logic                         resetn_i,
   input  wire logic                         psel_i,
   input  wire logic                         penable_i,
   input  wire logic                         pwrite_i,
   input  wire logic [lstat_pkg::ADDR_W-1:0] paddr_i,
   input  wire logic [31:0]                  pwdata_i,
   output logic                              pready_o,
   output logic [31:0]                       prdata_o,
   output logic                              pslverr_o,
   input  wire lstat_pkg::lstat_optics_t     optics_i,
   input  wire lstat_pkg::lstat_framer_t     framer_i,
   input  wire lstat_pkg::lstat_event_t      event_i,
   input  wire logic [7:0]                   path_signal_label_i
);
   import lstat_pkg::*;

   // ==========================================================
   // register map, byte addresses, one aligned word each
   //   000 control     bit 0 selects WAN framing, LAN after reset
   //   004 snapshot    write bit 0 to take a snapshot, reads zero
   //   008 flags       snapshot of the latched flags
   //   00c label       snapshot of the received path label
   //   010 to 028      snapshot counters, one word each
   //   02c live flags  latched flags of the running interval
   // any other address answers with an error and writes nothing.
   // reading never clears: software writes the snapshot bit once per
   // interval, so a slow or repeated read cannot lose a count.

   // ==========================================================
   // state
   lstat_state_t s_r;
   lstat_state_t s_nxt;

   logic [NUM_FLG-1:0] cond;
   logic [NUM_CNT-1:0] ev;
   logic               frame_lost_cond;
   logic               setup;
   logic               done;
   logic               take_snap;
   logic [11:0]        addr;
   logic               addr_ok;
   logic [31:0]        rdata;
   int unsigned        idx;

   // ==========================================================
   // conditions seen this cycle
   always_comb begin
      // frame timer runs off the framer alone, not gated by signal or clock loss
      frame_lost_cond = framer_i.frame_unlocked
                        && (s_r.unlock_cnt >= 32'(FRAME_LOST_CYC));
      cond = '0;
      cond[FLG_RX_ALARM_IND]   = optics_i.rx_err
                                 | optics_i.rx_lock_err
                                 | optics_i.rx_power_alarm;
      cond[FLG_RX_LOCK_ERR]    = optics_i.rx_lock_err;
      cond[FLG_RX_POWER_ALARM] = optics_i.rx_power_alarm;
      cond[FLG_SIGNAL_LOST]    = framer_i.signal_lost;
      cond[FLG_CLOCK_LOST]     = framer_i.clock_lost;
      cond[FLG_FRAME_UNLOCKED] = s_r.wan_mode & framer_i.frame_unlocked;
      cond[FLG_FRAME_LOST]     = frame_lost_cond;
      cond[FLG_POINTER_LOST]   = s_r.wan_mode & framer_i.pointer_lost;
      cond[FLG_HIGH_ERR_RATE]  = framer_i.high_error_rate;
      cond[FLG_LOCAL_FAULT]    = framer_i.local_fault;
      cond[FLG_REMOTE_FAULT]   = framer_i.remote_fault;

      ev = '0;
      ev[CNT_FRAME_CHECK] = event_i.frame_check_err;
      ev[CNT_BAD_PACKET]  = event_i.bad_packet;
      ev[CNT_GOOD_PACKET] = event_i.good_packet;
      ev[CNT_RX_FIFO]     = event_i.rx_fifo_err;
      ev[CNT_SECTION_PAR] = s_r.wan_mode & event_i.section_parity_err;
      ev[CNT_LINE_PAR]    = s_r.wan_mode & event_i.line_parity_err;
      ev[CNT_PATH_PAR]    = s_r.wan_mode & event_i.path_parity_err;
   end

   // ==========================================================
   // apb decode and read mux
   always_comb begin
      addr    = 12'(paddr_i);
      setup   = psel_i & penable_i & (s_r.st == ST_IDLE);
      done    = psel_i & penable_i & s_r.pready;
      addr_ok = 1'b1;
      rdata   = '0;
      idx     = 0;
      case (addr)
         REG_CTRL:       rdata[CTRL_WAN_BIT] = s_r.wan_mode;
         REG_SNAP:       rdata = '0;
         REG_FLAGS:      rdata[NUM_FLG-1:0] = s_r.snap_flags;
         REG_LABEL:      rdata[7:0] = s_r.snap_label;
         REG_LIVE_FLAGS: rdata[NUM_FLG-1:0] = s_r.flags;
         default: begin
            if (addr >= REG_CNT_BASE && addr < REG_LIVE_FLAGS && addr[1:0] == 2'b00) begin
               idx   = 32'((addr - REG_CNT_BASE) >> 2);
               rdata = 32'(s_r.snap_cnt[idx]);
            end else begin
               addr_ok = 1'b0;
            end
         end
      endcase
      // writing the take bit is the single atomic read point
      take_snap = done & pwrite_i & (addr == REG_SNAP) & pwdata_i[SNAP_TAKE_BIT];
   end

   // ==========================================================
   // next state
   always_comb begin
      s_nxt = s_r;

      // one wait state: data and pready are registered together, on the same edge
      case (s_r.st)
         ST_IDLE: begin
            if (setup) begin
               s_nxt.st      = ST_ACK;
               s_nxt.pready  = 1'b1;
               s_nxt.pslverr = ~addr_ok;
               s_nxt.prdata  = (pwrite_i || !addr_ok) ? 32'h00000000 : rdata;
            end
         end
         ST_ACK: begin
            s_nxt.st      = ST_IDLE;
            s_nxt.pready  = 1'b0;
            s_nxt.pslverr = 1'b0;
         end
         default: begin
            s_nxt.st     = ST_IDLE;
            s_nxt.pready = 1'b0;
         end
      endcase

      if (done && pwrite_i && addr == REG_CTRL) begin
         s_nxt.wan_mode = pwdata_i[CTRL_WAN_BIT];
      end

      // out of frame persistence timer, saturating at the limit
      if (!framer_i.frame_unlocked) begin
         s_nxt.unlock_cnt = '0;
      end else if (s_r.unlock_cnt < 32'(FRAME_LOST_CYC)) begin
         s_nxt.unlock_cnt = s_r.unlock_cnt + 32'h00000001;
      end

      s_nxt.label = path_signal_label_i;

      if (take_snap) begin
         s_nxt.snap_flags = s_r.flags | cond;
         s_nxt.snap_label = s_r.label;
         // a condition present in the snapshot cycle also stays latched, so none is lost
         s_nxt.flags      = cond;
      end else begin
         s_nxt.flags      = s_r.flags | cond;
      end

      for (int i = 0; i < NUM_CNT; i++) begin
         if (take_snap) begin
            s_nxt.snap_cnt[i] = s_r.cnt[i];
            s_nxt.cnt[i]      = CNT_W'(ev[i]);
         end else if (ev[i] && s_r.cnt[i] != {CNT_W{1'b1}}) begin
            // saturate rather than wrap so a long gap between reads never reads small
            s_nxt.cnt[i] = s_r.cnt[i] + CNT_W'(1);
         end
      end
   end

   // ==========================================================
   // register
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_r          <= '0;
         s_r.st       <= ST_IDLE;
         s_r.wan_mode <= CTRL_WAN_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign pready_o  = s_r.pready;
   assign prdata_o  = s_r.prdata;
   assign pslverr_o = s_r.pslverr;

endmodule

/* testbench/lstat_props.sv */
`timescale 1ns/10ps
// ==========
// bus answer checks
module lstat_props
   import lstat_pkg::*;
#(
   parameter int unsigned FRAME_LOST_CYC = 20
) (
   input wire logic          clk_i,
   input wire logic          resetn_i,
   input wire logic          psel_i,
   input wire logic          penable_i,
   input wire logic          pwrite_i,
   input wire logic [11:0]   paddr_i,
   input wire logic [31:0]   pwdata_i,
   input wire logic          pready_o,
   input wire logic [31:0]   prdata_o,
   input wire logic          pslverr_o,
   input wire lstat_optics_t optics_i,
   input wire lstat_framer_t framer_i,
   input wire lstat_event_t  event_i,
   input wire logic [7:0]    path_signal_label_i
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);
   wire acc = psel_i && penable_i && !pready_o;
   wire rd = pready_o && !pwrite_i;
   wire unmapped = paddr_i > REG_LIVE_FLAGS;
   wire mapped = !unmapped && paddr_i[1:0] == 2'b00;
   ready_pulse_a: assert property (pready_o |=> !pready_o)
      else $error("ready held too long");
   ready_answer_a: assert property (acc |=> pready_o)
      else $error("no ready one cycle after access");
   ready_cause_a: assert property (pready_o |-> psel_i && penable_i && $past(acc))
      else $error("ready without access");
   err_unmapped_a: assert property (acc && unmapped |=> pslverr_o && prdata_o == '0)
      else $error("unmapped access not refused");
   err_mapped_a: assert property (acc && mapped |=> !pslverr_o)
      else $error("mapped access refused");
   err_pulse_a: assert property (pslverr_o |-> pready_o)
      else $error("error without ready");
   label_top_a: assert property (rd && paddr_i == REG_LABEL |-> prdata_o[31:8] == '0)
      else $error("label word has extra bits");
   write_data_a: assert property (pready_o && pwrite_i |-> prdata_o == 0)
      else $error("read data on write");
   snap_read_a: assert property (rd && paddr_i == REG_SNAP |-> prdata_o == 0)
      else $error("snapshot control reads nonzero");
   flag_width_a: assert property (rd && paddr_i == REG_FLAGS |-> prdata_o[31:11] == 0)
      else $error("flags word has extra bits");
   cover property (acc && pwrite_i);
   cover property (rd && paddr_i == REG_FLAGS && prdata_o != 0);
   cover property (pslverr_o);
endmodule
bind lstat_top lstat_props #(.FRAME_LOST_CYC(FRAME_LOST_CYC)) lstat_props_i (
   .clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
   .prdata_o(prdata_o), .pslverr_o(pslverr_o), .optics_i(optics_i), .framer_i(framer_i),
   .event_i(event_i), .path_signal_label_i(path_signal_label_i));

/* testbench/lstat_optics_model.sv */
`timescale 1ns/10ps
// ==========
// optical module: receive error only ever comes with a cause
module lstat_optics_model
   import lstat_pkg::*;
(
   input  wire logic          lock_fail_i,
   input  wire logic          power_low_i,
   output lstat_optics_t      optics_o
);
   assign optics_o.rx_err = lock_fail_i | power_low_i;
   assign optics_o.rx_lock_err = lock_fail_i;
   // power_low_i stands for input power below the alarm threshold
   assign optics_o.rx_power_alarm = power_low_i;
endmodule

/* testbench/test_link_alarm_statistics.sv */
`timescale 1ns/10ps
module test_link_alarm_statistics;
   import lstat_pkg::*;
   localparam int unsigned LOST = 20;
   logic          clk_i, resetn_i, psel, penable, pwrite, pready, pslverr, er, lk, pw;
   logic [11:0]   paddr;
   logic [31:0]   pwdata, prdata, rd;
   logic [7:0]    label;
   lstat_optics_t optics;
   lstat_framer_t framer;
   lstat_event_t  events;
   int            miscompares, comparisons;
   // {wan, lock fail, power low, framer conditions, expected flags}
   logic [20:0]   rows [10] = '{
      {3'b010, 7'h00, 11'h003},
      {3'b001, 7'h00, 11'h005},
      {3'b000, 7'h40, 11'h008},
      {3'b000, 7'h20, 11'h010},
      {3'b100, 7'h10, 11'h020},
      {3'b000, 7'h18, 11'h000},
      {3'b100, 7'h08, 11'h080},
      {3'b000, 7'h04, 11'h100},
      {3'b000, 7'h02, 11'h200},
      {3'b000, 7'h01, 11'h400}};
   lstat_top #(.FRAME_LOST_CYC(LOST)) lstat_top_i (.clk_i(clk_i), .resetn_i(resetn_i),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
      .optics_i(optics), .framer_i(framer), .event_i(events), .path_signal_label_i(label));
   lstat_optics_model lstat_optics_model_i (.lock_fail_i(lk), .power_low_i(pw),
      .optics_o(optics));
   initial begin
      clk_i = 0;
      forever #10 clk_i = ~clk_i;
   end
   task automatic print_verdict();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         miscompares++;
         print_verdict();
      end else begin
         rd = prdata;
         er = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   // the snapshot write also restarts every interval
   task automatic snap();
      apb(1'b1, REG_SNAP, 32'h1);
      @(posedge clk_i);
   endtask
   initial begin
      {resetn_i, psel, penable, pwrite, lk, pw} = 0;
      {paddr, pwdata, framer, events, label} = 0;
      repeat (10) @(posedge clk_i);
      chk({31'h0, pready}, 32'h0);
      resetn_i <= 1'b1;
      apb(1'b0, REG_CTRL, 32'h0);
      chk(rd, 32'h0);
      foreach (rows[i]) begin
         apb(1'b1, REG_CTRL, {31'h0, rows[i][20]});
         snap();
         {lk, pw, framer} <= rows[i][19:11];
         repeat (3) @(posedge clk_i);
         {lk, pw, framer} <= 9'h0;
         apb(1'b0, REG_LIVE_FLAGS, 32'h0);
         chk(rd, {21'h0, rows[i][10:0]});
         snap();
         apb(1'b0, REG_FLAGS, 32'h0);
         chk(rd, {21'h0, rows[i][10:0]});
      end
      $display("flag table done");
      for (int w = 1; w >= 0; w--) begin
         apb(1'b1, REG_CTRL, 32'(w));
         snap();
         events <= 7'h7f;
         label <= w ? 8'h10 : 8'h01;
         repeat (3) @(posedge clk_i);
         events <= 7'h00;
         snap();
         for (int k = 0; k < NUM_CNT; k++) begin
            apb(1'b0, REG_CNT_BASE + 12'(4 * k), 32'h0);
            chk(rd, (w == 1 || k < 4) ? 32'h3 : 32'h0);
         end
         apb(1'b0, REG_LABEL, 32'h0);
         chk(rd, w ? 32'h10 : 32'h01);
      end
      $display("counter test done");
      for (int j = 0; j < 2; j++) begin
         framer <= 7'h10;
         repeat (LOST + j) @(posedge clk_i);
         framer <= 7'h00;
         snap();
         apb(1'b0, REG_FLAGS, 32'h0);
         chk(rd, j ? 32'h40 : 32'h0);
      end
      snap();
      apb(1'b0, REG_FLAGS, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h100, 32'h0);
      chk({31'h0, er}, 32'h1);
      apb(1'b0, REG_SNAP, 32'h0);
      chk(rd, 32'h0);
      $display("frame loss and refusal test done");
      apb(1'b1, REG_CTRL, 32'h1);
      apb(1'b0, REG_CTRL, 32'h0);
      chk(rd, 32'h1);
      framer <= 7'h7f;
      events <= 7'h7f;
      @(posedge clk_i);
      resetn_i <= 1'b0;
      framer <= 7'h00;
      events <= 7'h00;
      repeat (2) @(posedge clk_i);
      chk(prdata, 32'h0);
      chk({31'h0, pready | pslverr}, 32'h0);
      resetn_i <= 1'b1;
      apb(1'b0, REG_CTRL, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, REG_LIVE_FLAGS, 32'h0);
      chk(rd, 32'h0);
      snap();
      apb(1'b0, REG_CNT_BASE + 12'(4 * CNT_GOOD_PACKET), 32'h0);
      chk(rd, 32'h0);
      $display("mid-run reset test done");
      print_verdict();
   end
endmodule
